// >>> swdt_pkg.sv
// Purpose: shared constants and types for the system watchdog timer
// Assumes: 10 MHz system clock
// Notes: timing counts derive from the clock period
package swdt_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SEC_PER_MIN = 60;
   localparam int unsigned TICK_SEC_CYC = CLK_HZ;        // cycles in one second
   localparam int unsigned PRESCALE_W = 24;
   localparam int unsigned SEC_CNT_W = 6;
   localparam logic [7:0] TICKS_RST = 8'h01;             // timeout after reset
   localparam logic UNIT_SEC = 1'b0;
   localparam logic UNIT_MIN = 1'b1;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      SWDT_OP_NONE,
      SWDT_OP_INIT,
      SWDT_OP_SET,
      SWDT_OP_START,
      SWDT_OP_RESTART,
      SWDT_OP_STOP
   } swdt_op_t;

   typedef enum logic [1:0] {
      SWDT_IDLE,
      SWDT_RUN,
      SWDT_EXPIRED
   } swdt_state_t;

endpackage : swdt_pkg

// >>> swdt_tick_if.sv
// Purpose: tick strobe carrier between prescaler and watchdog core
// Assumes: one clock domain
// Notes: pulses last one cycle
`timescale 1ns/10ps
interface swdt_tick_if;
   logic clear;     // restart prescaler phase
   logic sec_tick;  // one-cycle pulse per second
   logic min_tick;  // one-cycle pulse per minute

   modport core (output clear, input sec_tick, input min_tick);
   modport prescaler (input clear, output sec_tick, output min_tick);
endinterface : swdt_tick_if

// >>> swdt_prescaler.sv
// Purpose: derives one-second and one-minute strobes from the system clock
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes: clear realigns both strobes so a fresh countdown gets full ticks
`timescale 1ns/10ps
module swdt_prescaler #(
   parameter int unsigned SEC_CYC = swdt_pkg::TICK_SEC_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   swdt_tick_if.prescaler tick
);
   import swdt_pkg::*;

   localparam logic [PRESCALE_W-1:0] SEC_LAST = PRESCALE_W'(SEC_CYC - 1);
   localparam logic [SEC_CNT_W-1:0] MIN_LAST = SEC_CNT_W'(SEC_PER_MIN - 1);

   logic [PRESCALE_W-1:0] cyc_q;
   logic [SEC_CNT_W-1:0] sec_q;

   // cycle divider for the second strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i || tick.clear || cyc_q == SEC_LAST) begin
         cyc_q <= '0;
      end else begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   // second strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i || tick.clear) begin
         tick.sec_tick <= 1'b0;
      end else begin
         tick.sec_tick <= (cyc_q == SEC_LAST);
      end
   end

   // seconds divider and minute strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i || tick.clear) begin
         sec_q <= '0;
         tick.min_tick <= 1'b0;
      end else begin
         tick.min_tick <= (cyc_q == SEC_LAST) && (sec_q == MIN_LAST);
         if (cyc_q == SEC_LAST) begin
            sec_q <= (sec_q == MIN_LAST) ? '0 : sec_q + 1'b1;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   min_on_sec_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      tick.min_tick |-> tick.sec_tick)
      else $error("minute strobe without second strobe");

endmodule : swdt_prescaler

// >>> swdt_core.sv
// Purpose: watchdog countdown driven by five software operations
// Assumes: operations arrive as one-cycle pulses on op_i from same-clock logic
// Notes: the reset request holds until system reset clears the block
//
// How it works
// - Expiry of the countdown while running raises the system reset request.
// - The timeout is an 8-bit tick count, a set of zero is refused so it stays within 1 to 255.
// - Unit 0 makes each tick one second.
// - Unit 1 makes each tick one minute.
// - Start loads the programmed timeout and begins counting down.
// - Restart while running reloads the last programmed timeout, giving a full new period.
// - Stop halts the countdown so no reset request can arise.
`timescale 1ns/10ps
module swdt_core #(
   parameter int unsigned SEC_CYC = swdt_pkg::TICK_SEC_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire swdt_pkg::swdt_op_t op_i,
   input wire logic [7:0] tick_count_i,
   input wire logic unit_i,
   output logic sys_reset_req_o,
   output logic running_o,
   output logic ready_o,
   output logic [7:0] remain_o
);
   import swdt_pkg::*;

   swdt_tick_if tick_bus ();

   swdt_state_t state_q;
   logic [7:0] reload_q;
   logic unit_q;
   logic run_unit_q;
   logic [7:0] cnt_q;
   logic clear_q;
   logic tick_sel;
   logic is_start;
   logic is_restart;

   // ****************************************
   // tick source
   // ****************************************
   swdt_prescaler #(
      .SEC_CYC(SEC_CYC)
   ) u_prescaler (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .tick(tick_bus.prescaler)
   );

   assign tick_bus.clear = clear_q;

   // unit selects which strobe moves the count
   assign tick_sel = (run_unit_q == UNIT_MIN) ? tick_bus.min_tick : tick_bus.sec_tick;
   // operations are honoured only once initialized; an expired timer waits for system reset
   assign is_start = ready_o && op_i == SWDT_OP_START && state_q != SWDT_EXPIRED;
   assign is_restart = ready_o && op_i == SWDT_OP_RESTART;

   // ****************************************
   // control
   // ****************************************

   // init gate; ops before init are dropped
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ready_o <= 1'b0;
      end else if (op_i == SWDT_OP_INIT) begin
         ready_o <= 1'b1;
      end
   end

   // timeout setting, zero is refused to keep the count meaningful
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         reload_q <= TICKS_RST;
         unit_q <= UNIT_SEC;
      end else if (ready_o && op_i == SWDT_OP_SET && tick_count_i != 8'h00) begin
         reload_q <= tick_count_i;
         unit_q <= unit_i;
      end
   end

   // unit taken at start and restart, so a later set cannot stretch or cut the running period
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         run_unit_q <= UNIT_SEC;
      end else if (is_start || (is_restart && state_q == SWDT_RUN)) begin
         run_unit_q <= unit_q;
      end
   end

   // prescaler realign on start and restart so each period is whole
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= is_start || (is_restart && state_q == SWDT_RUN);
      end
   end

   // state machine; expired stays until system reset
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= SWDT_IDLE;
      end else begin
         unique case (state_q)
            SWDT_IDLE: begin
               if (is_start) begin
                  state_q <= SWDT_RUN;
               end
            end
            SWDT_RUN: begin
               if (ready_o && op_i == SWDT_OP_STOP) begin
                  state_q <= SWDT_IDLE;
               end else if (!is_restart && !is_start && !clear_q && tick_sel && cnt_q == 8'h01) begin
                  state_q <= SWDT_EXPIRED;
               end
            end
            SWDT_EXPIRED: begin
               state_q <= SWDT_EXPIRED;
            end
            default: state_q <= SWDT_IDLE;
         endcase
      end
   end

   // countdown register
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt_q <= 8'h00;
      end else if (is_start || (is_restart && state_q == SWDT_RUN)) begin
         cnt_q <= reload_q;
      end else if (state_q == SWDT_RUN && !clear_q && tick_sel && cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sys_reset_req_o <= 1'b0;
         running_o <= 1'b0;
         remain_o <= 8'h00;
      end else begin
         sys_reset_req_o <= (state_q == SWDT_EXPIRED);
         running_o <= (state_q == SWDT_RUN);
         remain_o <= cnt_q;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   stop_no_req_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_IDLE) |=> !sys_reset_req_o)
      else $error("reset request while stopped");

   expire_req_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN && !clear_q && tick_sel && cnt_q == 8'h01 && op_i == SWDT_OP_NONE)
      |=> ##1 sys_reset_req_o)
      else $error("expiry did not raise reset request");

   start_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (is_start && state_q == SWDT_IDLE) |=> (cnt_q == $past(reload_q) && state_q == SWDT_RUN))
      else $error("start did not load timeout");

   restart_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (is_restart && state_q == SWDT_RUN) |=> cnt_q == $past(reload_q))
      else $error("restart did not reload");

   count_nonzero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN) |-> cnt_q != 8'h00)
      else $error("running with zero count");

   sec_step_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN && run_unit_q == UNIT_SEC && tick_bus.sec_tick && !clear_q && cnt_q > 8'h01
       && op_i == SWDT_OP_NONE) |=> cnt_q == $past(cnt_q) - 8'h01)
      else $error("second tick missed");

   min_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN && run_unit_q == UNIT_MIN && !tick_bus.min_tick && op_i == SWDT_OP_NONE)
      |=> cnt_q == $past(cnt_q))
      else $error("minute count moved without minute tick");

   reset_idle_a: assert property (@(posedge mclk_i)
      reset_i |=> (!sys_reset_req_o && !running_o && !ready_o))
      else $error("not stopped after reset");

   // nothing but init moves an uninitialized timer
   no_init_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      !ready_o |=> state_q == SWDT_IDLE)
      else $error("activity before init");

   // the request is a level that only system reset takes away
   req_latched_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      sys_reset_req_o |=> sys_reset_req_o)
      else $error("reset request dropped");

   stop_halts_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN && ready_o && op_i == SWDT_OP_STOP)
      |=> ##1 (!running_o && !sys_reset_req_o))
      else $error("stop did not halt the countdown");

   // expiry only ever follows the last selected tick of a running count
   expire_src_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_EXPIRED && $past(state_q) != SWDT_EXPIRED)
      |-> $past(state_q == SWDT_RUN && tick_sel && cnt_q == 8'h01))
      else $error("expiry without a final tick");

   // a set while running must not swap the tick source under the count
   unit_latch_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (state_q == SWDT_RUN && op_i != SWDT_OP_START && op_i != SWDT_OP_RESTART)
      |=> run_unit_q == $past(run_unit_q))
      else $error("running unit changed without start or restart");

   cv_start: cover property (@(posedge mclk_i) disable iff (reset_i) is_start);
   cv_restart: cover property (@(posedge mclk_i) disable iff (reset_i) is_restart && state_q == SWDT_RUN);
   cv_expire: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(sys_reset_req_o));
   cv_min_expire: cover property (@(posedge mclk_i) disable iff (reset_i)
      $rose(sys_reset_req_o) && run_unit_q == UNIT_MIN);
   cv_stop: cover property (@(posedge mclk_i) disable iff (reset_i)
      state_q == SWDT_RUN && op_i == SWDT_OP_STOP);

endmodule : swdt_core

// >>> system_watchdog_timer_tb.sv
// Purpose: self-checking bench for the watchdog countdown core
// Assumes: SEC_CYC is cut to 10 cycles, so a minute lasts 600 cycles
// Notes: inputs change on the falling edge; expiry is checked in a small window
`timescale 1ns/10ps
module system_watchdog_timer_tb;
   import swdt_pkg::*;
   localparam int unsigned SC = 10;
   logic mclk_i;
   logic reset_i;
   logic unit_i;
   logic sys_reset_req_o;
   logic running_o;
   logic ready_o;
   logic [7:0] tick_count_i;
   logic [7:0] remain_o;
   swdt_op_t op_i;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   typedef struct {logic [7:0] tk; logic un; int t;} swdt_row_t;
   // ticks, unit, expected timeout in cycles
   swdt_row_t rows[5] = '{'{8'h01, 1'b0, 10}, '{8'h03, 1'b0, 30}, '{8'hFF, 1'b0, 2550},
                          '{8'h01, 1'b1, 600}, '{8'h02, 1'b1, 1200}};

   swdt_core #(.SEC_CYC(SC)) i_swdt_core (.mclk_i(mclk_i), .reset_i(reset_i), .op_i(op_i),
      .tick_count_i(tick_count_i), .unit_i(unit_i), .sys_reset_req_o(sys_reset_req_o),
      .running_o(running_o), .ready_o(ready_o), .remain_o(remain_o));

   // ****************************************
   // clock, hang guard, tasks
   // ****************************************
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   // ceiling far above the ~5000 cycles the tests need
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : wait_cyc

   // one-cycle operation pulse, operands paired with it
   task automatic do_op(input swdt_op_t o, input logic [7:0] tk = 8'h00, input logic un = 1'b0);
      @(negedge mclk_i);
      op_i = o;
      tick_count_i = tk;
      unit_i = un;
      @(negedge mclk_i);
      op_i = SWDT_OP_NONE;
   endtask : do_op

   task automatic do_reset;
      @(negedge mclk_i);
      reset_i = 1'b1;
      wait_cyc(10);
      chk({5'h00, sys_reset_req_o, running_o, ready_o}, 8'h00);
      reset_i = 1'b0;
   endtask : do_reset

   // reload seen after start/restart, then expiry lands in a narrow window
   task automatic expect_expiry(input logic [7:0] tk, input int t);
      wait_cyc(2);
      chk(remain_o, tk);
      chk({7'h00, running_o}, 8'h01);
      wait_cyc(t - 5);
      chk({7'h00, sys_reset_req_o}, 8'h00);
      wait_cyc(8);
      chk({7'h00, sys_reset_req_o}, 8'h01);
   endtask : expect_expiry

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset_i = 1'b1;
      op_i = SWDT_OP_NONE;
      tick_count_i = 8'h00;
      unit_i = 1'b0;
      // ordinary timeouts, both units and the largest count
      foreach (rows[i]) begin
         do_reset();
         do_op(SWDT_OP_INIT);
         do_op(SWDT_OP_SET, rows[i].tk, rows[i].un);
         do_op(SWDT_OP_START);
         expect_expiry(rows[i].tk, rows[i].t);
      end
      // operations before init must leave the timer idle
      do_reset();
      do_op(SWDT_OP_SET, 8'h01);
      do_op(SWDT_OP_START);
      wait_cyc(30);
      chk({6'h00, sys_reset_req_o, running_o}, 8'h00);
      // zero count is ignored; restart reloads the last valid count
      do_op(SWDT_OP_INIT);
      do_op(SWDT_OP_SET, 8'h03);
      do_op(SWDT_OP_START);
      do_op(SWDT_OP_SET, 8'h00);
      wait_cyc(20);
      chk({7'h00, sys_reset_req_o}, 8'h00);
      do_op(SWDT_OP_RESTART);
      expect_expiry(8'h03, 30);
      // stop halts the count; restart while stopped does nothing
      do_reset();
      do_op(SWDT_OP_INIT);
      chk({7'h00, ready_o}, 8'h01);
      do_op(SWDT_OP_START);
      wait_cyc(4);
      do_op(SWDT_OP_STOP);
      wait_cyc(2);
      chk({7'h00, running_o}, 8'h00);
      do_op(SWDT_OP_RESTART);
      wait_cyc(60);
      chk({6'h00, sys_reset_req_o, running_o}, 8'h00);
      // default timeout is one second; a set during the run waits for the next start or restart
      do_op(SWDT_OP_START);
      do_op(SWDT_OP_SET, 8'h02, 1'b1);
      expect_expiry(TICKS_RST, SC);
      end_of_test();
   end

   task automatic end_of_test;
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
endmodule : system_watchdog_timer_tb
